// file: verilog/interrupt_mask_bank.sv
`include "irq_mask_defines.svh"

module interrupt_mask_bank (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic [7:0]                   regAddr,
    input  wire logic [7:0]                   regWrData,
    input  wire logic                         regWrite,
    input  wire logic                         regRead,
    output logic      [7:0]                   regRdData,
    output logic                              regRdValid,
    input  wire logic                         regResetCmd,
    input  wire irq_mask_pkg::event_flags_t   eventFlags,
    output logic      [`ALL_EVENT_COUNT-1:0]  pendingEvents,
    output logic                              hostInterrupt
);

    irq_mask_pkg::mask_power_good_t pgMask;
    irq_mask_pkg::mask_faults_t     faultMask;
    logic [7:0]                     pgValue;
    logic [7:0]                     faultValue;
    logic                           pgWrite;
    logic                           faultWrite;
    logic [7:0]                     rdData_reg;
    logic [7:0]                     rdData_next;
    logic                           rdValid_reg;
    logic                           rdValid_next;

    // Address match, shared by write strobes and read mux
    function automatic logic addrHits(input logic [7:0] addr,
                                      input logic [7:0] offset);
        addrHits = (addr == offset);
    endfunction

    // Write strobes per register
    assign pgWrite    = regWrite && addrHits(regAddr, `MASK_PG_OFFSET);
    assign faultWrite = regWrite &&
                        addrHits(regAddr, `MASK_FAULT_OFFSET);

    // Power-good mask: bits 7 and 6 masked after reset, rest open
    mask_register #(
        .RESET_VALUE (`MASK_PG_RESET),
        .WRITABLE    (`MASK_PG_WRITABLE)
    ) pgMaskReg (
        .clk       (clk),
        .resetn    (resetn),
        .regReset  (regResetCmd),
        .writeEn   (pgWrite),
        .writeData (regWrData),
        .value     (pgValue)
    );

    // Fault mask: all open after reset, upper nibble hardwired zero
    mask_register #(
        .RESET_VALUE (`MASK_FAULT_RESET),
        .WRITABLE    (`MASK_FAULT_WRITABLE)
    ) faultMaskReg (
        .clk       (clk),
        .resetn    (resetn),
        .regReset  (regResetCmd),
        .writeEn   (faultWrite),
        .writeData (regWrData),
        .value     (faultValue)
    );

    // Field views of the stored bytes
    assign pgMask    = irq_mask_pkg::mask_power_good_t'(pgValue);
    assign faultMask = irq_mask_pkg::mask_faults_t'(faultValue);

    // Event order matches mask bit order: charge status
    // sequence good rails input supply
    // then faults
    irq_gate gate (
        .clk       (clk),
        .resetn    (resetn),
        .flags     ({eventFlags.powerGood, eventFlags.faults}),
        .masks     ({pgMask.chargeStateChangeMask,
                     pgMask.powerSequenceGoodMask,
                     pgMask.stepDownOkMask,
                     pgMask.buckBoostOkMask,
                     pgMask.linreg1OkMask,
                     pgMask.linreg2OkMask,
                     pgMask.inputSupplyOkMask,
                     pgMask.inputOvervoltageMask,
                     faultMask.systemRailShortMask,
                     faultMask.batteryOvercurrentMask,
                     faultMask.batteryDepletionMask,
                     faultMask.thermalShutdownMask}),
        .pending   (pendingEvents),
        .interrupt (hostInterrupt)
    );

    // Read mux; unmapped addresses answer zero rather than stale data
    always_comb begin
        rdData_next  = rdData_reg;
        rdValid_next = regRead;
        if (regRead) begin
            if (addrHits(regAddr, `MASK_PG_OFFSET)) begin
                rdData_next = pgValue;
            end else if (addrHits(regAddr, `MASK_FAULT_OFFSET)) begin
                rdData_next = faultValue;
            end else begin
                rdData_next = `REG_UNMAPPED_DATA;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdData_reg  <= `REG_UNMAPPED_DATA;
            rdValid_reg <= 1'b0;
        end else begin
            rdData_reg  <= rdData_next;
            rdValid_reg <= rdValid_next;
        end
    end

    assign regRdData  = rdData_reg;
    assign regRdValid = rdValid_reg;

endmodule

// file: verilog/irq_mask_defines.svh
`ifndef IRQ_MASK_DEFINES_SVH
`define IRQ_MASK_DEFINES_SVH

// Register offsets on the serial register port
`define MASK_PG_OFFSET       8'h0a
`define MASK_FAULT_OFFSET    8'h0b

// Reset values, restored by power-on and the register-reset command
`define MASK_PG_RESET        8'hc0
`define MASK_FAULT_RESET     8'h00

// Bits that software may change; the rest read as zero
`define MASK_PG_WRITABLE     8'hff
`define MASK_FAULT_WRITABLE  8'h0f

// Answer to an unmapped address
`define REG_UNMAPPED_DATA    8'h00

// Event counts per register and in total
`define PG_EVENT_COUNT       8
`define FAULT_EVENT_COUNT    4
`define ALL_EVENT_COUNT      12

`endif

// file: verilog/irq_mask_pkg.sv
package irq_mask_pkg;

    // Power-good and supply mask fields, bit 7 first
    typedef struct packed {
        logic chargeStateChangeMask;
        logic powerSequenceGoodMask;
        logic stepDownOkMask;
        logic buckBoostOkMask;
        logic linreg1OkMask;
        logic linreg2OkMask;
        logic inputSupplyOkMask;
        logic inputOvervoltageMask;
    } mask_power_good_t;

    // Fault mask fields; upper nibble is reserved
    typedef struct packed {
        logic [3:0] reserved;
        logic       systemRailShortMask;
        logic       batteryOvercurrentMask;
        logic       batteryDepletionMask;
        logic       thermalShutdownMask;
    } mask_faults_t;

    // Event flags, each in the bit position of its mask
    typedef struct packed {
        logic [7:0] powerGood;
        logic [3:0] faults;
    } event_flags_t;

endpackage

// file: verilog/mask_register.sv
`include "irq_mask_defines.svh"

module mask_register #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITABLE    = 8'hff
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       regReset,
    input  wire logic       writeEn,
    input  wire logic [7:0] writeData,
    output logic      [7:0] value
);

    logic [7:0] value_reg;
    logic [7:0] value_next;

    // Reset command beats a same-cycle write; reserved bits stay zero
    always_comb begin
        value_next = value_reg;
        if (regReset) begin
            value_next = RESET_VALUE;
        end else if (writeEn) begin
            value_next = writeData & WRITABLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            value_reg <= RESET_VALUE;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;

endmodule

// file: verilog/irq_gate.sv
`include "irq_mask_defines.svh"

module irq_gate (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic [`ALL_EVENT_COUNT-1:0]  flags,
    input  wire logic [`ALL_EVENT_COUNT-1:0]  masks,
    output logic      [`ALL_EVENT_COUNT-1:0]  pending,
    output logic                              interrupt
);

    logic [`ALL_EVENT_COUNT-1:0] unmasked;
    logic [`ALL_EVENT_COUNT-1:0] pending_reg;
    logic [`ALL_EVENT_COUNT-1:0] pending_next;
    logic                        interrupt_reg;
    logic                        interrupt_next;

    // Mask bit 0 passes the event, 1 blocks it
    genvar i;
    generate
        for (i = 0; i < `ALL_EVENT_COUNT; i = i + 1) begin : gateBit
            assign unmasked[i] = flags[i] & ~masks[i];
        end
    endgenerate

    // Registered so the pin never glitches on a mask write
    always_comb begin
        pending_next   = unmasked;
        interrupt_next = |unmasked;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pending_reg   <= '0;
            interrupt_reg <= 1'b0;
        end else begin
            pending_reg   <= pending_next;
            interrupt_reg <= interrupt_next;
        end
    end

    assign pending   = pending_reg;
    assign interrupt = interrupt_reg;

endmodule

// file: testbench/irq_mask_bank_chk.sv
`include "irq_mask_defines.svh"

module irq_mask_bank_chk (
    input wire logic                        clk,
    input wire logic                        resetn,
    input wire logic [7:0]                  regAddr,
    input wire logic                        regWrite,
    input wire logic                        regRead,
    input wire logic [7:0]                  regRdData,
    input wire logic                        regRdValid,
    input wire logic                        regResetCmd,
    input wire irq_mask_pkg::event_flags_t  eventFlags,
    input wire logic [`ALL_EVENT_COUNT-1:0] pendingEvents,
    input wire logic                        hostInterrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Read port timing; data must not drift between reads
    a_read_answer: assert property (regRead |=> regRdValid)
        else $error("read strobe not answered");
    a_data_holds: assert property (!regRead |=> $stable(regRdData))
        else $error("read data moved without a read");
    a_valid_pulse: assert property (!regRead |=> !regRdValid)
        else $error("read valid without a read strobe");
    // Holes in the map and reserved bits read as zero
    a_unmapped_zero: assert property (regRead && !(regAddr inside
        {8'h0a, 8'h0b}) |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (regRead && regAddr == 8'h0b
        |=> regRdData[7:4] == 4'h0)
        else $error("reserved fault bits not zero");
    // Register-reset puts the defaults back at once
    a_defaults_back: assert property (regResetCmd ##1 regRead &&
        regAddr == 8'h0a |=> regRdData == 8'hc0)
        else $error("power-good mask not restored");
    a_default_gate: assert property (regResetCmd ##1 !regWrite
        |=> pendingEvents[11:10] == 2'b00)
        else $error("default-masked event pending");
    // A pending bit needs its flag one cycle earlier
    a_pending_cause: assert property (
        (pendingEvents & ~$past(eventFlags)) == '0)
        else $error("pending bit without flag");
    a_irq_any: assert property (hostInterrupt == |pendingEvents)
        else $error("interrupt not the OR of pending");
    c_irq: cover property (hostInterrupt);
    c_reg_reset: cover property (regResetCmd);
    c_fault_read: cover property (regRead && regAddr == 8'h0b);
endmodule

// file: testbench/host_model.sv
module host_model (
    input  wire logic       clk,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData,
    output logic            regWrite,
    output logic            regRead,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle on an unmapped offset so a stray strobe is harmless
    initial begin
        regAddr = 8'hff;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    // One-cycle write; data is scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
        regWrData = ~d;
    endtask
    // Answer comes one edge after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [8:0] r);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        r = {regRdValid, regRdData};
    endtask
endmodule

// file: testbench/interrupt_mask_bank_test.sv
module interrupt_mask_bank_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic                       clk, resetn, regResetCmd;
    logic [7:0]                 regAddr, regWrData, regRdData;
    logic                       regWrite, regRead, regRdValid, hostInterrupt;
    logic [11:0]                pendingEvents, m;
    logic [8:0]                 r;
    irq_mask_pkg::event_flags_t eventFlags;
    int                         nMismatch, checked, cycles;

    interrupt_mask_bank dut_u (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .regResetCmd(regResetCmd), .eventFlags(eventFlags),
        .pendingEvents(pendingEvents), .hostInterrupt(hostInterrupt));
    host_model host_u (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .regRdValid(regRdValid));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard, far above the roughly 120 cycles used
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            nMismatch++;
            end_sim;
        end
    end
    task automatic chk(input string n, input logic [11:0] s, e);
        checked++;
        if (s !== e) begin
            nMismatch++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Valid flag rides in bit 8 of the compare
    task automatic rdchk(input string n, input logic [7:0] a, e);
        host_u.rd(a, r);
        chk(n, {3'h0, r}, {4'h1, e});
    endtask
    task automatic t_defaults;
        rdchk("mask_pg", 8'h0a, 8'hc0);
        rdchk("mask_flt", 8'h0b, 8'h00);
        rdchk("unmapped", 8'h0c, 8'h00);
    endtask
    task automatic t_access;
        host_u.wr(8'h0a, 8'h5a);
        rdchk("pg_rw", 8'h0a, 8'h5a);
        host_u.wr(8'h0b, 8'hff);
        rdchk("flt_rw", 8'h0b, 8'h0f);
    endtask
    // One unmasked event at a time; battery assumed fitted
    task automatic t_gate;
        eventFlags = '1;
        for (int i = 0; i < 12; i++) begin
            m = ~(12'h001 << i);
            host_u.wr(8'h0a, m[11:4]);
            host_u.wr(8'h0b, {4'h0, m[3:0]});
            repeat (2) @(negedge clk);
            chk("pending", pendingEvents, ~m);
            chk("irq", {11'h0, hostInterrupt}, 12'h001);
        end
        eventFlags = '0;
        repeat (2) @(negedge clk);
        chk("irq_off", {11'h0, hostInterrupt}, 12'h000);
        // Every mask set with every flag up: nothing may get through
        eventFlags = '1;
        host_u.wr(8'h0a, 8'hff);
        host_u.wr(8'h0b, 8'h0f);
        repeat (2) @(negedge clk);
        chk("pend_masked", pendingEvents, 12'h000);
        chk("irq_masked", {11'h0, hostInterrupt}, 12'h000);
    endtask
    // Command restores defaults and beats a write on the same edge
    task automatic t_regreset;
        host_u.wr(8'h0a, 8'h00);
        eventFlags = '1;
        fork
            host_u.wr(8'h0b, 8'h0a);
            begin
                @(negedge clk);
                regResetCmd = 1'b1;
                @(negedge clk);
                regResetCmd = 1'b0;
            end
        join
        rdchk("flt_rst", 8'h0b, 8'h00);
        rdchk("pg_pulse", 8'h0a, 8'hc0);
        // Read right behind a held command, as the checker expects
        host_u.wr(8'h0a, 8'h00);
        @(negedge clk);
        regResetCmd = 1'b1;
        rdchk("pg_rst", 8'h0a, 8'hc0);
        regResetCmd = 1'b0;
        chk("pend_rst", pendingEvents, 12'h3ff);
    endtask
    task automatic end_sim;
        if (nMismatch == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        eventFlags = '0;
        regResetCmd = 1'b0;
        resetn = 1'b0;
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        t_defaults;
        t_access;
        t_gate;
        t_regreset;
        end_sim;
    end
endmodule

bind interrupt_mask_bank irq_mask_bank_chk chk_u (.clk(clk), .resetn(resetn),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .regResetCmd(regResetCmd), .eventFlags(eventFlags),
    .pendingEvents(pendingEvents), .hostInterrupt(hostInterrupt));
